// ===== hdl/mode_regs_map.vh
// Summary of operation
// (RQ1) low two bits pick output standard
// (RQ2) PAL M only on one variant
// (RQ3) bits 2-4 pick luma filter, any standard
// (RQ4) bits 5-7 pick chroma filter
// (RQ5) second register at one, read/write
// (RQ6) third register eight bits, at two, read/write
// (RQ7) bit 0 selects interlaced or not
// (RQ8) bits 1-2 select caption fields
// (RQ9) bits 3,5,6 power down each DAC
// (RQ10) host writes one into bit 4
// (RQ11) bit 7 outputs colour bar pattern
// (RQ12) colour bars force master timing mode
// (RQ13) square pixel only in slave timing
// (RQ14) bit 1 makes lock pin an input
// (RQ15) bit 2 zero: rising edge resets subcarrier
// (RQ16) bit 2 one: pin is real-time control
// (RQ17) bit 3 sets active line length
// (RQ18) bit 4 turns colour on or off
// (RQ19) bit 5 turns burst on or off
// (RQ20) bit 6 enables low power mode
// (RQ21) host writes zero into bit 7
// (RQ22) first register at zero, read/write
// (RQ23) DAC A and C powered down at reset
// (RQ24) reserved bits stored; whole-byte update
`ifndef MODE_REGS_MAP_VH
`define MODE_REGS_MAP_VH

// subaddresses
`define FIRST_MODE_ADDR   5'h00
`define SECOND_MODE_ADDR  5'h01
`define THIRD_MODE_ADDR   5'h02

// reset values
`define FIRST_MODE_RST    8'h00
`define SECOND_MODE_RST   8'h48
`define THIRD_MODE_RST    8'h00

// first mode register fields
`define STD_LSB           0
`define STD_MSB           1
`define LUMA_LSB          2
`define LUMA_MSB          4
`define CHROMA_LSB        5
`define CHROMA_MSB        7

// second mode register fields
`define INTERLACE_BIT     0
`define CAPTION_LSB       1
`define CAPTION_MSB       2
`define DAC_A_PD_BIT      3
`define RSVD_ONE_BIT      4
`define DAC_B_PD_BIT      5
`define DAC_C_PD_BIT      6
`define COLOUR_BAR_BIT    7

// third mode register fields
`define SQUARE_PIX_BIT    0
`define PIN_INPUT_BIT     1
`define PIN_FUNC_BIT      2
`define LINE_LEN_BIT      3
`define COLOUR_EN_BIT     4
`define BURST_EN_BIT      5
`define LOW_POWER_BIT     6
`define RSVD_ZERO_BIT     7

// output standard codes
`define STD_NTSC          2'h0
`define STD_PAL_BDGHI     2'h1
`define STD_PAL_M         2'h2
`define STD_PAL_N         2'h3

// caption field codes
`define CAP_NONE          2'h0
`define CAP_ODD           2'h1
`define CAP_EVEN          2'h2
`define CAP_BOTH          2'h3

// active line lengths in pixels
`define LINE_FULL         10'h2d0
`define LINE_NTSC_SHORT   10'h2c6
`define LINE_PAL_SHORT    10'h2be

`endif

// ===== hdl/subcarrier_lock_pin.v
`timescale 1ns/10ps
`include "mode_regs_map.vh"

// shared subcarrier reset / real-time control pin handling
module subcarrier_lock_pin (
   // clock and reset
   input  wire clk,
   input  wire rst,
   // configuration
   input  wire pin_input,
   input  wire pin_func,
   // pad
   input  wire pin_in,
   output reg  pin_out,
   output reg  pin_oe,
   // results
   output reg  subcarrier_reset,
   output reg  rtc_valid,
   output reg  rtc_data
);

   reg         pin_prev;
   wire        reset_mode;
   wire        rtc_mode;

   // pin acts only once it is an input
   assign reset_mode = pin_input & ~pin_func;
   assign rtc_mode   = pin_input & pin_func;

   // pad drive and edge detection
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out          <= 1'b0;
         pin_oe           <= 1'b0;
         pin_prev         <= 1'b0;
         subcarrier_reset <= 1'b0;
         rtc_valid        <= 1'b0;
         rtc_data         <= 1'b0;
      end else begin
         pin_out  <= 1'b0;
         // (RQ14) input when selected
         pin_oe   <= ~pin_input;
         pin_prev <= pin_in;
         // (RQ15) rising edge resets
         subcarrier_reset <= reset_mode & pin_in & ~pin_prev;
         // (RQ16) real-time control input
         rtc_valid <= rtc_mode;
         rtc_data  <= rtc_mode & pin_in;
      end
   end

endmodule

// ===== hdl/video_encoder_mode_registers.v
`timescale 1ns/10ps
`include "mode_regs_map.vh"

// first three mode registers of the encoder and their decoded controls
module video_encoder_mode_registers #(
   parameter PAL_M_SUPPORTED = 1
) (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // register port from the serial engine
   input  wire [4:0] reg_addr,
   input  wire       reg_wr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   output reg        reg_ack,
   output reg        reg_done,
   // timing mode asked for by the rest of the chip
   input  wire       timing_master_req,
   // raw register images
   output reg  [7:0] first_mode_control,
   output reg  [7:0] second_mode_control,
   output reg  [7:0] third_mode_control,
   // standard and filters
   output reg  [1:0] encoding_standard,
   output reg        std_is_pal,
   output reg  [2:0] luma_filter_select,
   output reg  [2:0] chroma_filter_select,
   // scan and captions
   output reg        interlace_select,
   output reg        caption_odd_en,
   output reg        caption_even_en,
   // DAC controls
   output reg        dac_a_on,
   output reg        dac_b_on,
   output reg        dac_c_on,
   output reg        low_power_enable,
   // test pattern and timing
   output reg        colour_bar_enable,
   output reg        bar_setup_en,
   output reg        master_timing,
   output reg        square_pixel_active,
   // line and colour
   output reg  [9:0] active_pixels,
   output reg        colour_enable,
   output reg        burst_enable,
   // subcarrier lock pin
   input  wire       lock_pin_in,
   output wire       lock_pin_out,
   output wire       lock_pin_oe,
   output wire       subcarrier_reset,
   output wire       rtc_valid,
   output wire       rtc_data
);

   reg  [7:0] next_first;
   reg  [7:0] next_second;
   reg  [7:0] next_third;
   reg  [1:0] eff_std;
   reg        eff_pal;
   reg        eff_master;
   reg  [9:0] eff_pixels;

   // address lies inside this bank
   function addr_hit;
      input [4:0] a;
      begin
         addr_hit = (a == `FIRST_MODE_ADDR) ||
                    (a == `SECOND_MODE_ADDR) ||
                    (a == `THIRD_MODE_ADDR);
      end
   endfunction

   // read data multiplexer
   function [7:0] read_mux;
      input [4:0] a;
      input [7:0] r0;
      input [7:0] r1;
      input [7:0] r2;
      begin
         case (a)
            `FIRST_MODE_ADDR:  read_mux = r0;
            `SECOND_MODE_ADDR: read_mux = r1;
            `THIRD_MODE_ADDR:  read_mux = r2;
            default:           read_mux = 8'h00;
         endcase
      end
   endfunction

   // next register values; a write loads the whole byte at once
   always @* begin
      next_first  = first_mode_control;
      next_second = second_mode_control;
      next_third  = third_mode_control;
      if (reg_wr) begin
         // (RQ24) whole-byte update
         case (reg_addr)
            // (RQ22) first register write
            `FIRST_MODE_ADDR:  next_first  = reg_wdata;
            // (RQ5) second register write
            `SECOND_MODE_ADDR: next_second = reg_wdata;
            // (RQ6) third register write
            `THIRD_MODE_ADDR:  next_third  = reg_wdata;
            default: begin
               next_first  = first_mode_control;
               next_second = second_mode_control;
               next_third  = third_mode_control;
            end
         endcase
      end
   end

   // effective standard after the variant check
   always @* begin
      eff_std = next_first[`STD_MSB:`STD_LSB];
      // (RQ2) PAL M only if supported
      if ((eff_std == `STD_PAL_M) && (PAL_M_SUPPORTED == 0)) begin
         eff_std = `STD_NTSC;
      end
      // (RQ1) PAL family detect
      eff_pal = (eff_std != `STD_NTSC);
   end

   // timing mode and active line length
   always @* begin
      // (RQ12) bars force master
      eff_master = next_second[`COLOUR_BAR_BIT] | timing_master_req;
      // (RQ17) line length choice
      if (!next_third[`LINE_LEN_BIT]) begin
         eff_pixels = `LINE_FULL;
      end else if (eff_std == `STD_NTSC) begin
         eff_pixels = `LINE_NTSC_SHORT;
      end else begin
         eff_pixels = `LINE_PAL_SHORT;
      end
   end

   // register storage; reserved bits keep what was written
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         first_mode_control  <= `FIRST_MODE_RST;
         // (RQ23) DAC A, C powered down
         second_mode_control <= `SECOND_MODE_RST;
         third_mode_control  <= `THIRD_MODE_RST;
      end else begin
         // (RQ24) reserved bits stored
         first_mode_control  <= next_first;
         second_mode_control <= next_second;
         third_mode_control  <= next_third;
      end
   end

   // read back and acknowledge towards the serial engine
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_ack   <= 1'b0;
         reg_done  <= 1'b0;
      end else begin
         reg_done <= reg_wr | reg_rd;
         if (reg_wr | reg_rd) begin
            reg_ack <= addr_hit(reg_addr);
         end
         if (reg_rd) begin
            // (RQ5) stored value read back
            reg_rdata <= read_mux(reg_addr, first_mode_control,
                                  second_mode_control,
                                  third_mode_control);
         end
      end
   end

   // decoded controls of the first register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         encoding_standard    <= `STD_NTSC;
         std_is_pal           <= 1'b0;
         luma_filter_select   <= 3'h0;
         chroma_filter_select <= 3'h0;
      end else begin
         // (RQ1) output standard
         encoding_standard    <= eff_std;
         std_is_pal           <= eff_pal;
         // (RQ3) luma filter, any standard
         luma_filter_select   <= next_first[`LUMA_MSB:`LUMA_LSB];
         // (RQ4) chroma filter select
         chroma_filter_select <= next_first[`CHROMA_MSB:`CHROMA_LSB];
      end
   end

   // decoded controls of the second register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         interlace_select  <= 1'b0;
         caption_odd_en    <= 1'b0;
         caption_even_en   <= 1'b0;
         dac_a_on          <= 1'b0;
         dac_b_on          <= 1'b1;
         dac_c_on          <= 1'b0;
         colour_bar_enable <= 1'b0;
         bar_setup_en      <= 1'b0;
      end else begin
         // (RQ7) interlace choice
         interlace_select <= next_second[`INTERLACE_BIT];
         // (RQ8) caption field choice
         caption_odd_en  <=
            (next_second[`CAPTION_MSB:`CAPTION_LSB] == `CAP_ODD) ||
            (next_second[`CAPTION_MSB:`CAPTION_LSB] == `CAP_BOTH);
         caption_even_en <=
            (next_second[`CAPTION_MSB:`CAPTION_LSB] == `CAP_EVEN) ||
            (next_second[`CAPTION_MSB:`CAPTION_LSB] == `CAP_BOTH);
         // (RQ9) per-DAC power down
         dac_a_on <= ~next_second[`DAC_A_PD_BIT];
         dac_b_on <= ~next_second[`DAC_B_PD_BIT];
         dac_c_on <= ~next_second[`DAC_C_PD_BIT];
         // (RQ11) colour bar pattern
         colour_bar_enable <= next_second[`COLOUR_BAR_BIT];
         // setup pedestal on bars for NTSC only
         bar_setup_en <= next_second[`COLOUR_BAR_BIT] & ~eff_pal;
      end
   end

   // decoded controls of the third register and timing mode
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         master_timing       <= 1'b0;
         square_pixel_active <= 1'b0;
         active_pixels       <= `LINE_FULL;
         colour_enable       <= 1'b0;
         burst_enable        <= 1'b0;
         low_power_enable    <= 1'b0;
      end else begin
         // (RQ12) master while bars on
         master_timing <= eff_master;
         // (RQ13) square pixel slave only
         square_pixel_active <= next_third[`SQUARE_PIX_BIT] &
                                ~eff_master;
         // (RQ17) active pixel count
         active_pixels <= eff_pixels;
         // (RQ18) colour on or off
         colour_enable <= next_third[`COLOUR_EN_BIT];
         // (RQ19) burst on or off
         burst_enable  <= next_third[`BURST_EN_BIT];
         // (RQ20) low power mode
         low_power_enable <= next_third[`LOW_POWER_BIT];
      end
   end

   // shared lock pin, configured from the third register
   subcarrier_lock_pin u_lock_pin (
      .clk              (clk),
      .rst              (rst),
      .pin_input        (third_mode_control[`PIN_INPUT_BIT]),
      .pin_func         (third_mode_control[`PIN_FUNC_BIT]),
      .pin_in           (lock_pin_in),
      .pin_out          (lock_pin_out),
      .pin_oe           (lock_pin_oe),
      .subcarrier_reset (subcarrier_reset),
      .rtc_valid        (rtc_valid),
      .rtc_data         (rtc_data)
   );

endmodule

// ===== bench/host_model.sv
`timescale 1ns/10ps
// host on the register port; drives on the falling edge
module host_model (
   // clock
   input  wire       clk,
   // register port
   output reg  [4:0] reg_addr,
   output reg        reg_wr,
   output reg  [7:0] reg_wdata,
   output reg        reg_rd,
   input  wire [7:0] reg_rdata
);
   // idle port
   initial begin
      reg_addr = 5'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end

   // one byte write, held over one rising edge
   task wr(input [4:0] a, input [7:0] d);
      begin
         @(negedge clk);
         reg_addr = a;
         reg_wdata = (a == 5'h01) ? (d | 8'h10) :
                     (a == 5'h02) ? (d & 8'h7f) : d;
         reg_wr = 1'b1;
         @(negedge clk);
         reg_wr = 1'b0;
      end
   endtask

   // one byte read, data taken after the answering edge
   task rd(input [4:0] a, output [7:0] d);
      begin
         @(negedge clk);
         reg_addr = a;
         reg_rd = 1'b1;
         @(negedge clk);
         reg_rd = 1'b0;
         d = reg_rdata;
      end
   endtask
endmodule

// ===== bench/mode_regs_sva.sv
`timescale 1ns/10ps
// port-level checks of the mode register block
module mode_regs_sva #(
   parameter PAL_M_SUPPORTED = 1
) (
   // clock and reset
   input wire       clk,
   input wire       rst,
   // register port
   input wire [4:0] reg_addr,
   input wire       reg_wr,
   input wire [7:0] reg_wdata,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   input wire       reg_ack,
   input wire       reg_done,
   // images and decodes
   input wire [7:0] first_mode_control,
   input wire [7:0] second_mode_control,
   input wire [7:0] third_mode_control,
   input wire [1:0] encoding_standard,
   input wire       std_is_pal,
   input wire [2:0] luma_filter_select,
   input wire [2:0] chroma_filter_select,
   input wire       dac_a_on,
   input wire       dac_c_on,
   input wire       colour_bar_enable,
   input wire       master_timing,
   input wire       square_pixel_active,
   input wire [9:0] active_pixels,
   input wire       lock_pin_in,
   input wire       subcarrier_reset
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_write_done: assert property (reg_wr |=> reg_done)
      else $error("no done after write");
   a_first_store: assert property ((reg_wr && reg_addr == 5'h00) |=>
      first_mode_control == $past(reg_wdata)) else $error("first not stored");
   a_second_store: assert property ((reg_wr && reg_addr == 5'h01) |=>
      second_mode_control == $past(reg_wdata)) else $error("second not stored");
   a_third_store: assert property ((reg_wr && reg_addr == 5'h02) |=>
      third_mode_control == $past(reg_wdata)) else $error("third not stored");
   a_third_read: assert property ((reg_rd && !reg_wr && reg_addr == 5'h02)
      |=> reg_ack && reg_rdata == $past(third_mode_control))
      else $error("third read wrong");
   a_bad_nak: assert property (((reg_wr || reg_rd) && reg_addr > 5'h02)
      |=> !reg_ack) else $error("bad address acknowledged");
   a_filter_fields: assert property (luma_filter_select ==
      first_mode_control[4:2] && chroma_filter_select ==
      first_mode_control[7:5]) else $error("filter fields wrong");
   a_dac_bits: assert property (dac_a_on == !second_mode_control[3] &&
      dac_c_on == !second_mode_control[6]) else $error("dac power wrong");
   a_bars_master: assert property (colour_bar_enable |-> master_timing
      && second_mode_control[7]) else $error("bars without master");
   a_square_slave: assert property (master_timing [*2] |->
      !square_pixel_active) else $error("square pixel in master");
   a_line_len: assert property (active_pixels == (!third_mode_control[3] ?
      10'h2d0 : std_is_pal ? 10'h2be : 10'h2c6)) else $error("line length");
   a_pal_m_variant: assert property (encoding_standard == 2'h2 |->
      PAL_M_SUPPORTED != 0) else $error("pal m on wrong variant");
   a_scr_edge: assert property (subcarrier_reset |-> $past(lock_pin_in)
      && !$past(lock_pin_in, 2)) else $error("reset without rising edge");
endmodule

bind video_encoder_mode_registers mode_regs_sva #(
   .PAL_M_SUPPORTED(PAL_M_SUPPORTED)
) chk_i (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
   .reg_ack, .reg_done, .first_mode_control, .second_mode_control,
   .third_mode_control, .encoding_standard, .std_is_pal, .luma_filter_select,
   .chroma_filter_select, .dac_a_on, .dac_c_on, .colour_bar_enable,
   .master_timing, .square_pixel_active, .active_pixels, .lock_pin_in,
   .subcarrier_reset);

// ===== bench/testbench.sv
`timescale 1ns/10ps
// self-checking bench for the mode register block
module testbench;
   reg        clk;
   reg        rst;
   reg        timing_master_req;
   reg        lock_pin_in;
   reg  [7:0] rd_val;
   integer    errors;
   integer    n_checks;
   integer    i;
   integer    cnt;
   wire [4:0] reg_addr;
   wire [7:0] reg_wdata, reg_rdata, second_mode_control, third_mode_control;
   wire       reg_wr, reg_rd, reg_ack, interlace_select, caption_odd_en;
   wire       caption_even_en, dac_a_on, dac_b_on, dac_c_on, master_timing;
   wire       low_power_enable, colour_bar_enable, square_pixel_active;
   wire       colour_enable, burst_enable, lock_pin_oe, subcarrier_reset;
   wire       rtc_valid, rtc_data, bar_setup_en;
   wire [1:0] encoding_standard;
   wire [2:0] luma_filter_select, chroma_filter_select;
   wire [9:0] active_pixels;

   video_encoder_mode_registers #(.PAL_M_SUPPORTED(1)) uut (.clk, .rst,
      .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_ack,
      .reg_done(), .timing_master_req, .first_mode_control(),
      .second_mode_control, .third_mode_control, .encoding_standard,
      .std_is_pal(), .luma_filter_select, .chroma_filter_select,
      .interlace_select, .caption_odd_en, .caption_even_en, .dac_a_on,
      .dac_b_on, .dac_c_on, .low_power_enable, .colour_bar_enable,
      .bar_setup_en, .master_timing, .square_pixel_active, .active_pixels,
      .colour_enable, .burst_enable, .lock_pin_in, .lock_pin_out(),
      .lock_pin_oe, .subcarrier_reset, .rtc_valid, .rtc_data);

   host_model host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // compare and count
   task chk(input string nm, input [9:0] e, input [9:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   // counts and verdict
   task test_done;
      begin
         $display("checks %0d errors %0d", n_checks, errors);
         if (errors == 0 && n_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   // reset values
   task t_reset;
      begin
         chk("second", 10'h048, second_mode_control);
         chk("dacs", 10'h002, {dac_a_on, dac_b_on, dac_c_on});
         chk("pixels", 10'h2d0, active_pixels);
         chk("pin oe", 10'h001, lock_pin_oe);
      end
   endtask

   // store and read back, unmapped address refused
   task t_regs;
      begin
         host.wr(5'h00, 8'ha5);
         host.rd(5'h00, rd_val);
         chk("first", 10'h0a5, rd_val);
         host.wr(5'h01, 8'h6e);
         host.rd(5'h01, rd_val);
         chk("second", 10'h07e, rd_val);
         host.wr(5'h02, 8'hff);
         host.rd(5'h02, rd_val);
         chk("third", 10'h07f, rd_val);
         host.wr(5'h03, 8'h55);
         chk("bad ack", 10'h000, reg_ack);
         host.rd(5'h1f, rd_val);
         chk("bad read", 10'h000, rd_val);
         chk("third kept", 10'h07f, third_mode_control);
      end
   endtask

   // every standard code, luma following the loop
   task t_std;
      for (i = 0; i < 4; i = i + 1) begin
         host.wr(5'h00, {3'h5, i[2:0], i[1:0]});
         chk("standard", i, encoding_standard);
         chk("luma", i, luma_filter_select);
         chk("chroma", 10'h005, chroma_filter_select);
      end
   endtask

   // scan, captions, DACs, bars
   task t_mode1;
      begin
         host.wr(5'h01, 8'h87);
         chk("mode1 a", 10'h0ff, {interlace_select, caption_odd_en,
            caption_even_en, dac_a_on, dac_b_on, dac_c_on, colour_bar_enable,
            master_timing});
         chk("bar setup pal", 10'h000, bar_setup_en);
         host.wr(5'h00, 8'h00);
         chk("bar setup ntsc", 10'h001, bar_setup_en);
         host.wr(5'h01, 8'h6a);
         chk("mode1 b", 10'h040, {interlace_select, caption_odd_en,
            caption_even_en, dac_a_on, dac_b_on, dac_c_on, colour_bar_enable,
            master_timing});
         host.wr(5'h01, 8'h04);
         chk("mode1 c", 10'h001, {caption_odd_en, caption_even_en});
      end
   endtask

   // square pixel, line length, colour, burst, low power
   task t_mode2;
      begin
         host.wr(5'h00, 8'h00);
         host.wr(5'h02, 8'hf9);
         chk("mode2", 10'h00f, {square_pixel_active, colour_enable,
            burst_enable, low_power_enable});
         chk("ntsc line", 10'h2c6, active_pixels);
         timing_master_req = 1'b1;
         repeat (2) @(negedge clk);
         chk("square master", 10'h000, square_pixel_active);
         timing_master_req = 1'b0;
         host.wr(5'h00, 8'h01);
         chk("pal line", 10'h2be, active_pixels);
         host.wr(5'h02, 8'h00);
         chk("off", 10'h000, {colour_enable, burst_enable});
      end
   endtask

   // lock pin as subcarrier reset, then as real-time control
   task t_pin;
      begin
         host.wr(5'h02, 8'h02);
         @(negedge clk);
         chk("pin oe", 10'h000, lock_pin_oe);
         lock_pin_in = 1'b1;
         cnt = 0;
         repeat (4) @(negedge clk) cnt = cnt + subcarrier_reset;
         chk("sc pulses", 10'h001, cnt);
         host.wr(5'h02, 8'h06);
         lock_pin_in = 1'b0;
         repeat (2) @(negedge clk);
         lock_pin_in = 1'b1;
         cnt = 0;
         repeat (4) @(negedge clk) cnt = cnt + subcarrier_reset;
         chk("rtc pulses", 10'h000, cnt);
         chk("rtc", 10'h003, {rtc_valid, rtc_data});
      end
   endtask

   // main sequence
   initial begin
      errors = 0;
      n_checks = 0;
      rst = 1'b1;
      timing_master_req = 1'b0;
      lock_pin_in = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset;
      t_regs;
      t_std;
      t_mode1;
      t_mode2;
      t_pin;
      test_done;
   end

   // hang guard
   initial begin
      #2000000;
      errors = errors + 1;
      test_done;
   end
endmodule
